/* logic/prio_bits_pkg.sv */
package prio_bits_pkg;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned ADDR_W       = 8;
	// byte addresses of the register words
	localparam logic [7:0]  CC_OFFSET    = 8'h00;
	localparam logic [7:0]  VPRIO_OFFSET = 8'h04;
	localparam int unsigned VPRIO_REGS   = 4;
	localparam int unsigned PAIRS_PER_REG = 4;
	// field positions in the condition code register
	localparam int unsigned PRIO_HI_POS  = 5;
	localparam int unsigned PRIO_LO_POS  = 3;
	localparam int unsigned STORED_W     = 6;
	localparam logic [1:0]  FIXED_ONES   = 2'h3;
	// value after reset: bits 5..0 = 1 0 1 0 1 0, bit 4 taken as 0
	localparam logic [5:0]  CC_RESET     = 6'h2A;
	localparam logic [1:0]  VPRIO_RESET  = 2'h3;
	localparam logic [3:0]  READ_ONLY_HI = 4'hF;
	// priority pair codes {high, low}
	localparam logic [1:0]  PAIR_LEVEL0  = 2'h2;
	localparam logic [1:0]  PAIR_LEVEL1  = 2'h1;
	localparam logic [1:0]  PAIR_LEVEL2  = 2'h0;
	localparam logic [1:0]  PAIR_LEVEL3  = 2'h3;
	typedef logic [1:0] prio_pair_t;
endpackage : prio_bits_pkg

/* logic/cpu_interrupt_priority_bits.sv */
`timescale 1ns/1ns
module cpu_interrupt_priority_bits
	import prio_bits_pkg::*;
#(
	parameter int unsigned NUM_VECTORS = 14
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [prio_bits_pkg::ADDR_W-1:0] paddr,
	input  wire logic [prio_bits_pkg::DATA_W-1:0] pwdata,
	output logic      [prio_bits_pkg::DATA_W-1:0] prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          irq_entry,
	input  wire logic [3:0]                    irq_vector,
	input  wire logic                          irq_top,
	input  wire logic                          irq_enable_instr,
	input  wire logic                          irq_disable_instr,
	input  wire logic                          halt_instr,
	input  wire logic                          wait_for_irq_instr,
	input  wire logic                          irq_return_instr,
	input  wire logic                          pop_cc_instr,
	input  wire logic [7:0]                    pop_data,
	output logic      [7:0]                    cc_value,
	output logic                               priority_bit_high,
	output logic                               priority_bit_low,
	output logic      [1:0]                    run_level,
	output logic                               maskable_blocked
);
	import prio_bits_pkg::*;

	initial begin
		if (NUM_VECTORS < 1 || NUM_VECTORS > 14)
			$error("NUM_VECTORS must lie between 1 and 14");
	end

	////////////////////////////////////////////////////////////////////////////
	// storage

	logic [STORED_W-1:0] cc_reg;
	logic [STORED_W-1:0] cc_next;
	prio_pair_t          vprio_reg [VPRIO_REGS*PAIRS_PER_REG];
	logic [DATA_W-1:0]   prdata_reg;
	logic [DATA_W-1:0]   prdata_next;

	////////////////////////////////////////////////////////////////////////////
	// apb decode

	wire        setup_phase = psel & ~penable;
	wire        access      = psel & penable;
	wire        hit_cc      = (paddr == CC_OFFSET);
	wire [7:0]  vp_rel      = paddr - VPRIO_OFFSET;
	wire        hit_vprio   = (paddr >= VPRIO_OFFSET) && (vp_rel[1:0] == 2'h0)
	                          && (vp_rel[7:2] < 6'(VPRIO_REGS));
	wire [1:0]  vp_index    = vp_rel[3:2];
	wire        mapped      = hit_cc | hit_vprio;
	wire        wr_cc       = access & pwrite & hit_cc;
	wire        wr_vprio    = access & pwrite & hit_vprio;

	// zero wait states: read data is captured at the setup edge
	assign pready  = access;
	assign pslverr = access & ~mapped;
	assign prdata  = prdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// condition code view

	assign cc_value          = {FIXED_ONES, cc_reg};
	assign priority_bit_high = cc_reg[PRIO_HI_POS];
	assign priority_bit_low  = cc_reg[PRIO_LO_POS];

	wire prio_pair_t cur_pair = {priority_bit_high, priority_bit_low};

	assign run_level = (cur_pair == PAIR_LEVEL0) ? 2'h0 :
	                   (cur_pair == PAIR_LEVEL1) ? 2'h1 :
	                   (cur_pair == PAIR_LEVEL2) ? 2'h2 : 2'h3;
	assign maskable_blocked = (cur_pair == PAIR_LEVEL3);

	////////////////////////////////////////////////////////////////////////////
	// vector priority registers

	// unused or out of range vectors fall back to level 3, the safe choice
	wire        vec_ok     = (32'(irq_vector) < NUM_VECTORS);
	wire prio_pair_t vec_pair = vec_ok ? vprio_reg[irq_vector] : PAIR_LEVEL3;
	wire prio_pair_t entry_pair = irq_top ? PAIR_LEVEL3 : vec_pair;

	genvar gv;
	generate
		for (gv = 0; gv < VPRIO_REGS*PAIRS_PER_REG; gv++) begin : g_vprio
			localparam int unsigned REG_I = gv / PAIRS_PER_REG;
			localparam int unsigned BIT_I = 2 * (gv % PAIRS_PER_REG);
			wire prio_pair_t wr_pair = pwdata[BIT_I +: 2];
			// level 0 cannot be written, old value is kept
			wire wr_hit = wr_vprio && (vp_index == 2'(REG_I)) && (wr_pair != PAIR_LEVEL0)
			              && (gv < NUM_VECTORS);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					vprio_reg[gv] <= VPRIO_RESET;
				else if (wr_hit)
					vprio_reg[gv] <= wr_pair;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// next value of the condition code bits

	// core events win over a software bus write in the same cycle
	always_comb begin
		cc_next = cc_reg;
		if (irq_entry) begin
			cc_next[PRIO_HI_POS] = entry_pair[1];
			cc_next[PRIO_LO_POS] = entry_pair[0];
		end else if (irq_return_instr || pop_cc_instr) begin
			cc_next = pop_data[STORED_W-1:0];
		end else if (irq_disable_instr) begin
			cc_next[PRIO_HI_POS] = PAIR_LEVEL3[1];
			cc_next[PRIO_LO_POS] = PAIR_LEVEL3[0];
		end else if (irq_enable_instr || halt_instr || wait_for_irq_instr) begin
			cc_next[PRIO_HI_POS] = PAIR_LEVEL0[1];
			cc_next[PRIO_LO_POS] = PAIR_LEVEL0[0];
		end else if (wr_cc) begin
			cc_next = pwdata[STORED_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cc_reg <= CC_RESET;
		else
			cc_reg <= cc_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// read data

	always_comb begin
		prdata_next = prdata_reg;
		if (setup_phase) begin
			prdata_next = '0;
			if (hit_cc) begin
				prdata_next[7:0] = cc_value;
			end else if (hit_vprio) begin
				prdata_next[7:0] = {vprio_reg[4*vp_index+3], vprio_reg[4*vp_index+2],
				                    vprio_reg[4*vp_index+1], vprio_reg[4*vp_index]};
				if (vp_index == 2'(VPRIO_REGS-1))
					prdata_next[7:4] = READ_ONLY_HI;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= '0;
		else
			prdata_reg <= prdata_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic rst_seen;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rst_seen <= 1'b1;
		else
			rst_seen <= 1'b0;
	end

	AST_RESET_VALUE: assert property (rst_seen |-> (cc_value == 8'hEA))
		else $error("condition code not at reset value");

	AST_HIGH_BIT_WRITE: assert property (
		wr_cc && !irq_entry && !irq_return_instr && !pop_cc_instr && !irq_disable_instr
		&& !irq_enable_instr && !halt_instr && !wait_for_irq_instr
		|=> priority_bit_high == $past(pwdata[5]) && priority_bit_low == $past(pwdata[3]))
		else $error("software write of priority bits lost");

	AST_LOW_BIT_READ: assert property (
		setup_phase && hit_cc |=> prdata[3] == $past(priority_bit_low)
		&& prdata[5] == $past(priority_bit_high))
		else $error("priority bits read back wrong");

	AST_LEVEL_MASK: assert property (
		maskable_blocked == (run_level == 2'h3))
		else $error("masking disagrees with level");

	AST_ENTRY_LOAD: assert property (
		irq_entry && !irq_top && vec_ok |=> cur_pair == $past(vprio_reg[irq_vector]))
		else $error("entry did not load vector priority");

	AST_ENTRY_STABLE: assert property (
		irq_entry ##1 !irq_entry && !irq_return_instr && !pop_cc_instr && !irq_disable_instr
		&& !irq_enable_instr && !halt_instr && !wait_for_irq_instr && !wr_cc
		|=> $stable(cur_pair))
		else $error("priority bits moved without a cause");

	AST_POP_RESTORE: assert property (
		!irq_entry && (irq_return_instr || pop_cc_instr)
		|=> cc_value[5:0] == $past(pop_data[5:0]))
		else $error("popped value not restored");

	AST_ENABLE_LEVEL0: assert property (
		irq_enable_instr && !irq_entry && !irq_return_instr && !pop_cc_instr && !irq_disable_instr
		|=> run_level == 2'h0 && cur_pair == 2'h2)
		else $error("enable did not select level 0");

	AST_DISABLE_LEVEL3: assert property (
		irq_disable_instr && !irq_entry && !irq_return_instr && !pop_cc_instr
		|=> maskable_blocked ##0 run_level == 2'h3)
		else $error("disable did not select level 3");

	AST_TOP_LEVEL3: assert property (irq_entry && irq_top |=> cur_pair == 2'h3)
		else $error("top level entry not at level 3");

	AST_LEVEL_CODE: assert property (
		cur_pair == 2'h1 |-> run_level == 2'h1)
		else $error("level 1 code decoded wrong");

	AST_FIXED_ONES: assert property (cc_value[7:6] == 2'h3)
		else $error("fixed upper bits not one");

	////////////////////////////////////////////////////////////////////////////
	// further checks on loads and codes

	AST_HALT_LEVEL0: assert property (
		halt_instr && !irq_entry && !irq_return_instr && !pop_cc_instr && !irq_disable_instr
		|=> cur_pair == PAIR_LEVEL0)
		else $error("halt did not select level 0");

	AST_WAIT_LEVEL0: assert property (
		wait_for_irq_instr && !irq_entry && !irq_return_instr && !pop_cc_instr && !irq_disable_instr
		|=> cur_pair == PAIR_LEVEL0)
		else $error("wait did not select level 0");

	AST_LEVEL0_CODE: assert property (
		cur_pair == 2'h2 |-> run_level == 2'h0)
		else $error("level 0 code decoded wrong");

	AST_LEVEL2_CODE: assert property (
		cur_pair == 2'h0 |-> run_level == 2'h2)
		else $error("level 2 code decoded wrong");

	// level 0 is refused in the vector table so a vector can never undercut main
	AST_VPRIO_KEEP: assert property (
		wr_vprio && vp_index == 2'h0 && pwdata[1:0] == PAIR_LEVEL0
		|=> $stable(vprio_reg[0]))
		else $error("level 0 write changed a vector pair");

	AST_VPRIO_WRITE: assert property (
		wr_vprio && vp_index == 2'h0 && pwdata[1:0] != PAIR_LEVEL0
		|=> vprio_reg[0] == $past(pwdata[1:0]))
		else $error("vector pair write lost");

	AST_OUT_OF_RANGE: assert property (
		irq_entry && !irq_top && !vec_ok |=> cur_pair == PAIR_LEVEL3)
		else $error("unknown vector did not mask");

	AST_ENTRY_WINS: assert property (
		irq_entry && wr_cc |=> cur_pair == $past(entry_pair))
		else $error("bus write beat interrupt entry");

	AST_ENTRY_ONLY_PAIR: assert property (
		irq_entry |=> cc_value[4] == $past(cc_value[4]) && cc_value[2:0] == $past(cc_value[2:0]))
		else $error("entry touched other bits");

	AST_UNMAPPED_NO_WRITE: assert property (
		access && pwrite && !mapped && !irq_entry && !irq_return_instr && !pop_cc_instr
		&& !irq_disable_instr && !irq_enable_instr && !halt_instr && !wait_for_irq_instr
		|=> $stable(cc_value))
		else $error("unmapped write changed the register");

endmodule : cpu_interrupt_priority_bits

/* testbench/core_model.sv */
`timescale 1ns/1ns
// core side: cmd 1 entry, 2 top entry, 3 enable, 4 disable, 5 halt, 6 wait, 7 return, 8 pop
module core_model (
	input  wire logic [3:0] cmd,
	input  wire logic [3:0] vec,
	input  wire logic [7:0] data,
	output logic            irq_entry,
	output logic [3:0]      irq_vector,
	output logic            irq_top,
	output logic            irq_enable_instr,
	output logic            irq_disable_instr,
	output logic            halt_instr,
	output logic            wait_for_irq_instr,
	output logic            irq_return_instr,
	output logic            pop_cc_instr,
	output logic [7:0]      pop_data
);
	assign irq_entry = (cmd == 4'h1) || (cmd == 4'h2);
	assign irq_top = (cmd == 4'h2);
	// idle buses show the inverse so a stale value is never mistaken for valid
	assign irq_vector = irq_entry ? vec : ~vec;
	assign irq_enable_instr = (cmd == 4'h3);
	assign irq_disable_instr = (cmd == 4'h4);
	assign halt_instr = (cmd == 4'h5);
	assign wait_for_irq_instr = (cmd == 4'h6);
	assign irq_return_instr = (cmd == 4'h7);
	assign pop_cc_instr = (cmd == 4'h8);
	assign pop_data = (irq_return_instr || pop_cc_instr) ? data : ~data;
endmodule : core_model

/* testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import prio_bits_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_entry, irq_top, en_i, dis_i, halt_i, wfi_i, ret_i, pop_i;
	logic pbh, pbl, blk;
	logic [7:0] paddr, cc_value, pop_data, data, byte_v;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] cmd, vec, irq_vector;
	logic [1:0] run_level;
	logic [5:0] cc;
	logic e;
	prio_pair_t vp [16];
	int errors, num_checks, seed;
	cpu_interrupt_priority_bits u_cpu_interrupt_priority_bits (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_entry(irq_entry), .irq_vector(irq_vector), .irq_top(irq_top),
		.irq_enable_instr(en_i), .irq_disable_instr(dis_i), .halt_instr(halt_i), .wait_for_irq_instr(wfi_i),
		.irq_return_instr(ret_i), .pop_cc_instr(pop_i), .pop_data(pop_data), .cc_value(cc_value),
		.priority_bit_high(pbh), .priority_bit_low(pbl), .run_level(run_level), .maskable_blocked(blk));
	core_model u_core_model (.cmd(cmd), .vec(vec), .data(data), .irq_entry(irq_entry), .irq_vector(irq_vector),
		.irq_top(irq_top), .irq_enable_instr(en_i), .irq_disable_instr(dis_i), .halt_instr(halt_i),
		.wait_for_irq_instr(wfi_i), .irq_return_instr(ret_i), .pop_cc_instr(pop_i), .pop_data(pop_data));
	////////////////////////////////////////////////////////////////////////
	task test_done;
		if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	// zero wait states expected, but the wait is bounded anyway
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
		if (n >= 20) begin
			errors++;
			test_done();
		end
	endtask : apb
	function automatic logic [1:0] lvl(input logic [1:0] p);
		return (p == 2'h2) ? 2'h0 : (p == 2'h1) ? 2'h1 : (p == 2'h0) ? 2'h2 : 2'h3;
	endfunction : lvl
	function automatic logic [5:0] nxt(input logic [3:0] c, input logic [3:0] v, input logic [7:0] d, input logic [5:0] cur);
		logic [1:0] p;
		p = {cur[5], cur[3]};
		case (c)
			4'h1: p = (v < 4'hE) ? vp[v] : 2'h3;
			4'h2, 4'h4: p = PAIR_LEVEL3;
			4'h3, 4'h5, 4'h6: p = PAIR_LEVEL0;
			4'h7, 4'h8: return d[5:0];
			default: ;
		endcase
		return {p[1], cur[4], p[0], cur[2:0]};
	endfunction : nxt
	task cc_chk;
		chk("cc", {24'h0, cc_value}, {24'h0, 2'h3, cc});
		chk("hi", {31'h0, pbh}, {31'h0, cc[5]});
		chk("lo", {31'h0, pbl}, {31'h0, cc[3]});
		chk("level", {30'h0, run_level}, {30'h0, lvl({cc[5], cc[3]})});
		chk("blocked", {31'h0, blk}, {31'h0, {cc[5], cc[3]} == 2'h3});
	endtask : cc_chk
	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		seed = 32'h7947;
		{presetn, psel, penable, pwrite, paddr, pwdata, cmd, vec, data} = '0;
		foreach (vp[i]) vp[i] = 2'h3;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		cc = CC_RESET;
		apb(1'b0, CC_OFFSET, 32'h0);
		chk("cc reset", r, 32'hEA);
		cc_chk();
		apb(1'b1, 8'h40, 32'hFF);
		chk("unmapped err", {31'h0, e}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			byte_v = 8'($random(seed)) ^ {2'h0, i[0], 1'b0, i[1], 3'h0};
			apb(1'b1, CC_OFFSET, {24'h0, byte_v});
			cc = byte_v[5:0];
			apb(1'b0, CC_OFFSET, 32'h0);
			chk("cc rw", r, {24'h0, 2'h3, cc});
			cc_chk();
		end
		repeat (4) begin
			for (int i = 0; i < 4; i++) begin
				byte_v = 8'($random(seed));
				apb(1'b1, VPRIO_OFFSET + 8'(4 * i), {24'h0, byte_v});
				for (int k = 0; k < 4; k++) if (byte_v[2*k+:2] != PAIR_LEVEL0) vp[4*i+k] = byte_v[2*k+:2];
				vp[14] = 2'h3;
				vp[15] = 2'h3;
				apb(1'b0, VPRIO_OFFSET + 8'(4 * i), 32'h0);
				chk("vprio", r, {24'h0, vp[4*i+3], vp[4*i+2], vp[4*i+1], vp[4*i]});
			end
			repeat (25) begin
				cmd <= 4'(unsigned'($random(seed)) % 8 + 1);
				vec <= 4'($random(seed));
				data <= 8'($random(seed));
				@(posedge pclk);
				cc = nxt(cmd, vec, data, cc);
				cmd <= 4'h0;
				@(posedge pclk);
				cc_chk();
			end
		end
		test_done();
	end
endmodule : tb_top
